//--- dv/fsb_fault_latch_checker.sv
`timescale 1ns/1ps

module fsb_fault_latch_checker (
    input wire logic       i_clk,
    input wire logic       i_sys_rst,
    input wire logic       i_chip_sel_n,
    input wire logic [5:0] i_bridge_overcurrent,
    input wire logic       i_bridge_six_recovery_enable,
    input wire logic       i_bridge_five_recovery_enable,
    input wire logic       i_bridge_four_recovery_enable,
    input wire logic [2:0] o_bridge_off,
    input wire logic [2:0] o_bridge_recovery,
    input wire logic       i_lin_tx_dominant_timeout,
    input wire logic       i_lin_bus_stuck_recessive,
    input wire logic       i_can_rx_missed,
    input wire logic       i_can_bus_missed,
    input wire logic       i_can_tx_dominant_timeout,
    input wire logic       o_lin_tx_disable,
    input wire logic       o_can_tx_disable
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);

    ////////////////////////////////////////////////////////////////
    // transmitter disables follow their causes by one edge
    chk_lin_txd_off: assert property (
        i_lin_tx_dominant_timeout |=> o_lin_tx_disable) else $error("lin tx not disabled");
    chk_lin_rec_off: assert property (
        i_lin_bus_stuck_recessive |=> o_lin_tx_disable) else $error("lin tx not disabled");
    chk_can_txd_off: assert property (
        i_can_tx_dominant_timeout |=> o_can_tx_disable) else $error("can tx not disabled");
    // a stuck-dominant bus alone must never switch the can driver off
    chk_can_off_cause: assert property (
        $rose(o_can_tx_disable) |-> $past(i_can_rx_missed || i_can_bus_missed || i_can_tx_dominant_timeout))
        else $error("can tx disabled without cause");

    ////////////////////////////////////////////////////////////////
    // bridge shutdown versus recovery
    chk_bridge_off_set: assert property (
        (|i_bridge_overcurrent[1:0] && !i_bridge_four_recovery_enable) |=> o_bridge_off[0])
        else $error("bridge four not off");
    chk_bridge_rec_go: assert property (
        (|i_bridge_overcurrent[5:4] && i_bridge_six_recovery_enable) |=> o_bridge_recovery[2])
        else $error("bridge six not in recovery");
    chk_bridge_rec_why: assert property (
        o_bridge_recovery[1] |-> $past(i_bridge_five_recovery_enable)) else $error("recovery while disabled");

    ////////////////////////////////////////////////////////////////
    // latched flags drop only after a frame has ended
    chk_lin_hold_sel: assert property (
        $fell(o_lin_tx_disable) |-> i_chip_sel_n && $past(i_chip_sel_n, 3))
        else $error("lin disable dropped in frame");
    chk_bridge_hold: assert property (
        $fell(o_bridge_off[0]) |-> i_chip_sel_n) else $error("bridge off dropped in frame");
endmodule : fsb_fault_latch_checker

bind fsb_fault_latch fsb_fault_latch_checker u_chk (
    .i_clk                        (i_clk),
    .i_sys_rst                    (i_sys_rst),
    .i_chip_sel_n                 (i_chip_sel_n),
    .i_bridge_overcurrent         (i_bridge_overcurrent),
    .i_bridge_six_recovery_enable (i_bridge_six_recovery_enable),
    .i_bridge_five_recovery_enable(i_bridge_five_recovery_enable),
    .i_bridge_four_recovery_enable(i_bridge_four_recovery_enable),
    .o_bridge_off                 (o_bridge_off),
    .o_bridge_recovery            (o_bridge_recovery),
    .i_lin_tx_dominant_timeout    (i_lin_tx_dominant_timeout),
    .i_lin_bus_stuck_recessive    (i_lin_bus_stuck_recessive),
    .i_can_rx_missed              (i_can_rx_missed),
    .i_can_bus_missed             (i_can_bus_missed),
    .i_can_tx_dominant_timeout    (i_can_tx_dominant_timeout),
    .o_lin_tx_disable             (o_lin_tx_disable),
    .o_can_tx_disable             (o_can_tx_disable)
);

//--- dv/fsb_host_model.sv
`timescale 1ns/1ps

module fsb_host_model (
    output logic      o_sck,
    output logic      o_chip_sel_n,
    output logic      o_sdi,
    input  wire logic i_sdo
);
    initial begin
        o_sck = 1'b0;
        o_chip_sel_n = 1'b1;
        o_sdi = 1'b0;
    end

    // one frame, msb first; the serial clock stands still outside frames
    task frame(input logic [1:0] op, input logic [5:0] addr, input int nb, input logic par_ok,
               output logic [31:0] rd);
        logic [31:0] w;
        w = {op, addr, 24'h0};
        if (^w == 1'b0) w[0] = 1'b1;
        if (!par_ok) w[0] = ~w[0];
        rd = '0;
        o_chip_sel_n = 1'b0;
        #125;
        for (int i = 0; i < nb; i++) begin
            o_sdi = w[31-i];
            #62.5 o_sck = 1'b1;
            rd = {rd[30:0], i_sdo};
            #62.5 o_sck = 1'b0;
        end
        #125 o_chip_sel_n = 1'b1;
        // data line released: show the opposite level, not the last bit
        o_sdi = ~o_sdi;
        #250;
    endtask : frame

    // select held low with the clock still, long enough to run out the select limit
    task stall(input int ns);
        o_chip_sel_n = 1'b0;
        #(ns) o_chip_sel_n = 1'b1;
        #250;
    endtask : stall
endmodule : fsb_host_model

//--- dv/tb_fault_status_latch_bank.sv
`timescale 1ns/1ps

module tb_fault_status_latch_bank;
    // detector vector: [36:28] switches, [27:22] bridges, [21:13] transceivers,
    // [12:9] drain monitors, [8:4] pump/thermal/regulators, [3:0] supplies
    localparam logic [36:0] RXM = 37'h1 << 18;
    localparam logic [36:0] BSM = 37'h1 << 17;
    localparam logic [36:0] FOL = 37'h1 << 16;
    localparam logic [36:0] CDM = 37'h1 << 15;
    logic        i_clk = 1'b0;
    logic        i_sys_rst = 1'b1;
    logic [36:0] det = '0;
    logic [2:0]  ren = '0;
    logic        sck, csn, sdi, sdo, sdo_en, ldis, cdis;
    logic [2:0]  boff, brec;
    logic [31:0] rd;
    int          err_count = 0;
    int          n_checks = 0;
    int          cyc = 0;

    always #5 i_clk = ~i_clk;

    fsb_fault_latch #(.CS_TIMEOUT_CYCLES(2000)) dut (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_sck(sck), .i_chip_sel_n(csn), .i_sdi(sdi),
        .o_sdo(sdo), .o_sdo_en(sdo_en), .i_switch_overcurrent(det[36:28]),
        .i_bridge_overcurrent(det[27:22]), .i_bridge_six_recovery_enable(ren[2]),
        .i_bridge_five_recovery_enable(ren[1]), .i_bridge_four_recovery_enable(ren[0]),
        .o_bridge_off(boff), .o_bridge_recovery(brec), .i_lin_bus_dominant_timeout(det[21]),
        .i_lin_tx_dominant_timeout(det[20]), .i_lin_bus_stuck_recessive(det[19]),
        .i_can_rx_missed(det[18]), .i_can_bus_missed(det[17]), .i_can_tx_followed(det[16]),
        .i_can_bus_stuck_dominant(det[15]), .i_can_tx_dominant_timeout(det[14]),
        .i_can_silence_timeout(det[13]), .o_lin_tx_disable(ldis), .o_can_tx_disable(cdis),
        .i_ext_drain_monitor(det[12:9]), .i_charge_pump_low(det[8]), .i_thermal_warning(det[7]),
        .i_reg_two_short(det[6]), .i_reg_two_fail(det[5]), .i_reg_one_fail(det[4]),
        .i_supply_fault(det[3:0]));

    fsb_host_model host (.o_sck(sck), .o_chip_sel_n(csn), .o_sdi(sdi), .i_sdo(sdo));

    ////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // one-cycle detector pulse, launched and dropped on falling edges
    task pl(input logic [36:0] v);
        @(negedge i_clk) det = v;
        @(negedge i_clk) det = '0;
    endtask : pl

    task results;
        $display("errors=%0d checks=%0d", err_count, n_checks);
        if (err_count == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : results

    ////////////////////////////////////////////////////////////////
    task t_overcurrent;
        pl({9'h1ff, 6'h3f, 22'h0});
        chk(boff, 3'h7);
        host.frame(2'h1, 6'h06, 32, 1'b1, rd);
        chk(rd, {8'h80, 24'h3f7fc0});
        host.frame(2'h2, 6'h06, 32, 1'b1, rd);
        chk(rd[23:0], 24'h3f7fc0);
        host.frame(2'h1, 6'h06, 32, 1'b1, rd);
        chk(rd, 32'h0);
        chk(boff, 3'h0);
    endtask : t_overcurrent

    task t_recovery;
        @(negedge i_clk) ren = 3'h7;
        det = {9'h0, 6'h3f, 22'h0};
        @(negedge i_clk) det = '0;
        chk(brec, 3'h7);
        host.frame(2'h1, 6'h06, 32, 1'b1, rd);
        chk(rd[23:0], 24'h0);
        chk(boff, 3'h0);
        ren = 3'h0;
    endtask : t_recovery

    // the receive miss counter must restart after a good echo
    task t_link;
        pl(CDM);
        for (int i = 0; i < 7; i++) pl(i == 3 ? FOL : RXM);
        chk(cdis, 1'b0);
        pl(RXM);
        chk(cdis, 1'b1);
        host.frame(2'h2, 6'h07, 32, 1'b1, rd);
        chk(rd, {8'h40, 24'h140000});
        chk(cdis, 1'b0);
        for (int i = 0; i < 4; i++) pl(BSM);
        chk(cdis, 1'b1);
        host.frame(2'h2, 6'h07, 32, 1'b1, rd);
        chk(rd[23:0], 24'h080000);
        pl({15'h0, 9'h1c7, 13'h1fff});
        chk({ldis, cdis}, 2'h3);
        host.frame(2'h2, 6'h07, 32, 1'b1, rd);
        chk(rd[23:0], 24'he7f3ef);
        chk({ldis, cdis}, 2'h0);
    endtask : t_link

    // refused frames set the invalid flag, or the clock count flag when short, and clear nothing
    task t_bad_frames;
        logic [8:0] tbl [4];
        tbl = '{{2'h0, 6'h07, 1'b1}, {2'h3, 6'h07, 1'b1}, {2'h1, 6'h05, 1'b1}, {2'h2, 6'h07, 1'b0}};
        pl(37'h1 << 7);
        foreach (tbl[i]) begin
            host.frame(tbl[i][8:7], tbl[i][6:1], 32, tbl[i][0], rd);
            host.frame(2'h1, 6'h07, 32, 1'b1, rd);
            chk(rd[23:0], 24'h000900);
        end
        host.frame(2'h2, 6'h07, 32, 1'b1, rd);
        host.frame(2'h2, 6'h07, 31, 1'b1, rd);
        host.frame(2'h2, 6'h07, 32, 1'b1, rd);
        chk(rd[23:0], 24'h000400);
    endtask : t_bad_frames

    // a select held past the limit drops the frame and releases data out
    task t_timeout;
        fork
            host.stall(25000);
            begin
                repeat (100) @(negedge i_clk);
                chk(sdo_en, 1'b1);
                repeat (2000) @(negedge i_clk);
                chk(sdo_en, 1'b0);
            end
        join
        host.frame(2'h2, 6'h07, 32, 1'b1, rd);
        chk(rd, {8'h40, 24'h000800});
        chk(sdo_en, 1'b0);
    endtask : t_timeout

    ////////////////////////////////////////////////////////////////
    // hang guard: the whole sequence needs about 11000 cycles
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 40000) begin
            err_count++;
            results();
        end
    end

    initial begin
        repeat (10) @(negedge i_clk);
        i_sys_rst = 1'b0;
        repeat (5) @(negedge i_clk);
        t_overcurrent();
        t_recovery();
        t_link();
        t_bad_frames();
        t_timeout();
        results();
    end
endmodule : tb_fault_status_latch_bank

//--- src/fsb_fault_latch.sv
// Contract
// - overcurrent at 0x06, link/supply at 0x07
// - flags stay set until read-and-clear
// - switch shutdown sets bits 21-16, 14-12
// - recovery off: flag set, bridge off
// - recovery on: no flag, recovery mode
// - LIN bus dominant timeout sets bit 23
// - LIN transmit dominant: bit 22, transmitter off
// - LIN bus not following: bit 21, off
// - CAN receive missed 4 times: bit 20, off
// - CAN bus missed 4 times: bit 19, off
// - CAN bus dominant: bit 18, transmitter stays
// - CAN transmit dominant: bit 17, transmitter off
// - CAN silence timeout sets bit 16
// - bits 15-12 latch drain-source monitors
// - bad frame ignored, bit 11 set
// - wrong clock count sets bit 10
// - charge pump bit 9, thermal bit 8
// - regulator two short sets bit 7
// - regulator fails set bits 6, 5
// - bits 3-0 supply threshold crossings
`timescale 1ns/1ps
`include "fsb_regs.svh"

module fsb_fault_latch #(
    parameter int unsigned CS_TIMEOUT_CYCLES = `FSB_CS_TIMEOUT_US * `FSB_CLK_MHZ,
    parameter int unsigned CAN_FAIL_COUNT    = `FSB_CAN_FAIL_COUNT
) (
    input  wire logic       i_clk,
    input  wire logic       i_sys_rst,
    // serial register port, asynchronous to i_clk
    input  wire logic       i_sck,
    input  wire logic       i_chip_sel_n,
    input  wire logic       i_sdi,
    output logic            o_sdo,
    output logic            o_sdo_en,
    // output stage detectors
    input  wire logic [8:0] i_switch_overcurrent,
    input  wire logic [5:0] i_bridge_overcurrent,
    input  wire logic       i_bridge_six_recovery_enable,
    input  wire logic       i_bridge_five_recovery_enable,
    input  wire logic       i_bridge_four_recovery_enable,
    output logic      [2:0] o_bridge_off,
    output logic      [2:0] o_bridge_recovery,
    // transceiver detectors
    input  wire logic       i_lin_bus_dominant_timeout,
    input  wire logic       i_lin_tx_dominant_timeout,
    input  wire logic       i_lin_bus_stuck_recessive,
    input  wire logic       i_can_rx_missed,
    input  wire logic       i_can_bus_missed,
    input  wire logic       i_can_tx_followed,
    input  wire logic       i_can_bus_stuck_dominant,
    input  wire logic       i_can_tx_dominant_timeout,
    input  wire logic       i_can_silence_timeout,
    output logic            o_lin_tx_disable,
    output logic            o_can_tx_disable,
    // bridge monitors and supplies
    input  wire logic [3:0] i_ext_drain_monitor,
    input  wire logic       i_charge_pump_low,
    input  wire logic       i_thermal_warning,
    input  wire logic       i_reg_two_short,
    input  wire logic       i_reg_two_fail,
    input  wire logic       i_reg_one_fail,
    input  wire logic [3:0] i_supply_fault
);

    localparam fsb_pkg::fsb_top_t TOP_RST = '{
        state    : fsb_pkg::FSB_IDLE,
        cs_sync  : 2'h3,
        cs_prev  : 1'b1,
        default  : '0
    };

    fsb_pkg::fsb_top_t s;
    fsb_pkg::fsb_top_t next_s;

    logic [23:0] flags_oc;
    logic [23:0] flags_ls;
    logic [23:0] set_oc;
    logic [23:0] set_ls;
    logic [5:0]  bridge_set;
    logic [5:0]  bridge_en;
    logic        rx_fail;
    logic        bus_fail;

    ////////////////////////////////////////////////////////////////////////////
    // the two flag registers
    fsb_sticky_flags #(
        .WIDTH (24),
        .MASK  (`FSB_MASK_OVERCURRENT)
    ) u_overcurrent_shutdown_flags (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_set     (set_oc),
        .i_clear   (s.clr_oc),
        .o_flags   (flags_oc)
    );

    fsb_sticky_flags #(
        .WIDTH (24),
        .MASK  (`FSB_MASK_LINK_SUPPLY)
    ) u_link_supply_fault_flags (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_set     (set_ls),
        .i_clear   (s.clr_ls),
        .o_flags   (flags_ls)
    );

    ////////////////////////////////////////////////////////////////////////////
    // event vectors into the flag registers
    always_comb begin
        // each half bridge enable covers its high and low side
        bridge_en  = {{2{i_bridge_six_recovery_enable}},
                      {2{i_bridge_five_recovery_enable}},
                      {2{i_bridge_four_recovery_enable}}};
        bridge_set = i_bridge_overcurrent & ~bridge_en;
        rx_fail    = i_can_rx_missed
                     & (s.can_rx_miss == 3'(CAN_FAIL_COUNT - 1));
        bus_fail   = i_can_bus_missed
                     & (s.can_bus_miss == 3'(CAN_FAIL_COUNT - 1));
        set_oc     = {2'h0,
                      i_switch_overcurrent[8:3],
                      1'b0,
                      i_switch_overcurrent[2:0],
                      bridge_set,
                      6'h00};
        set_ls     = {i_lin_bus_dominant_timeout,
                      i_lin_tx_dominant_timeout,
                      i_lin_bus_stuck_recessive,
                      rx_fail,
                      bus_fail,
                      i_can_bus_stuck_dominant,
                      i_can_tx_dominant_timeout,
                      i_can_silence_timeout,
                      i_ext_drain_monitor,
                      s.inv_frame,
                      s.clk_cnt_err,
                      i_charge_pump_low,
                      i_thermal_warning,
                      i_reg_two_short,
                      i_reg_two_fail,
                      i_reg_one_fail,
                      1'b0,
                      i_supply_fault};
    end

    ////////////////////////////////////////////////////////////////////////////
    // serial frame engine and protection outputs
    always_comb begin
        logic       sck_rise;
        logic       sck_fall;
        logic       cs_fall;
        logic       cs_rise;
        logic [7:0] head;
        logic [5:0] tx_idx;
        logic [1:0] op;
        logic [5:0] addr;
        logic       bad;
        sck_rise = 1'b0;
        sck_fall = 1'b0;
        cs_fall  = 1'b0;
        cs_rise  = 1'b0;
        head     = 8'h00;
        tx_idx   = 6'h00;
        op       = 2'h0;
        addr     = 6'h00;
        bad      = 1'b0;
        next_s   = s;

        // two flops on every serial port pin before any logic looks at it
        next_s.sck_sync = {s.sck_sync[0], i_sck};
        next_s.cs_sync  = {s.cs_sync[0], i_chip_sel_n};
        next_s.sdi_sync = {s.sdi_sync[0], i_sdi};
        next_s.sck_prev = s.sck_sync[1];
        next_s.cs_prev  = s.cs_sync[1];
        sck_rise = s.sck_sync[1] & ~s.sck_prev;
        sck_fall = ~s.sck_sync[1] & s.sck_prev;
        cs_fall  = ~s.cs_sync[1] & s.cs_prev;
        cs_rise  = s.cs_sync[1] & ~s.cs_prev;

        // one-cycle pulses default low
        next_s.clk_cnt_err = 1'b0;
        next_s.inv_frame   = 1'b0;
        next_s.clr_oc      = 24'h000000;
        next_s.clr_ls      = 24'h000000;

        case (s.state)
            fsb_pkg::FSB_IDLE: begin
                if (cs_fall) begin
                    next_s.state    = fsb_pkg::FSB_SHIFT;
                    next_s.bit_cnt  = 6'h00;
                    next_s.frame    = 32'h00000000;
                    next_s.snap     = 24'h000000;
                    next_s.cs_timer = 32'h00000000;
                    next_s.glob     = {|flags_oc, |flags_ls, 6'h00};
                    next_s.sdo      = |flags_oc;
                    next_s.sdo_en   = 1'b1;
                end
            end
            fsb_pkg::FSB_SHIFT: begin
                next_s.cs_timer = s.cs_timer + 32'h00000001;
                if (sck_rise) begin
                    // saturate so an overlong frame never wraps back to a legal count
                    if (s.bit_cnt != 6'h3f) begin
                        next_s.bit_cnt = s.bit_cnt + 6'h01;
                    end
                    next_s.frame = {s.frame[30:0], s.sdi_sync[1]};
                    if (s.bit_cnt == `FSB_HEAD_BITS - 6'h01) begin
                        head = {s.frame[6:0], s.sdi_sync[1]};
                        if (head[5:0] == `FSB_ADDR_OVERCURRENT) begin
                            next_s.snap = flags_oc;
                        end else if (head[5:0] == `FSB_ADDR_LINK_SUPPLY) begin
                            next_s.snap = flags_ls;
                        end else begin
                            next_s.snap = 24'h000000;
                        end
                    end
                end
                // data out changes on the falling clock, head byte first
                if (sck_fall) begin
                    if (s.bit_cnt < `FSB_HEAD_BITS) begin
                        tx_idx     = 6'h07 - s.bit_cnt;
                        next_s.sdo = s.glob[tx_idx[2:0]];
                    end else if (s.bit_cnt < `FSB_FRAME_BITS) begin
                        tx_idx     = 6'h1f - s.bit_cnt;
                        next_s.sdo = s.snap[tx_idx[4:0]];
                    end else begin
                        next_s.sdo = 1'b0;
                    end
                end
                if (cs_rise) begin
                    next_s.state  = fsb_pkg::FSB_IDLE;
                    next_s.sdo    = 1'b0;
                    next_s.sdo_en = 1'b0;
                    op            = s.frame[31:30];
                    addr          = s.frame[29:24];
                    bad = (~^s.frame)                                    // odd parity expected
                          | (&s.frame) | (~|s.frame)                     // data input stuck
                          | (op == `FSB_OP_WRITE)                        // status is read only
                          | (op == `FSB_OP_UNDEFINED)
                          | ((addr != `FSB_ADDR_OVERCURRENT) && (addr != `FSB_ADDR_LINK_SUPPLY));
                    if (s.bit_cnt != `FSB_FRAME_BITS) begin
                        next_s.clk_cnt_err = 1'b1;
                    end else if (bad) begin
                        next_s.inv_frame = 1'b1;
                    end else if (op == `FSB_OP_READ_CLEAR) begin
                        // clear only what was shown, later events survive
                        if (addr == `FSB_ADDR_OVERCURRENT) begin
                            next_s.clr_oc = s.snap;
                        end else begin
                            next_s.clr_ls = s.snap;
                        end
                    end
                end else if (s.cs_timer == 32'(CS_TIMEOUT_CYCLES - 1)) begin
                    next_s.inv_frame = 1'b1;
                    next_s.state     = fsb_pkg::FSB_ABORT;
                    next_s.sdo       = 1'b0;
                    next_s.sdo_en    = 1'b0;
                end
            end
            fsb_pkg::FSB_ABORT: begin
                // timed-out frame is dropped whole, wait for deselect
                if (cs_rise) begin
                    next_s.state = fsb_pkg::FSB_IDLE;
                end
            end
            default: begin
                next_s.state  = fsb_pkg::FSB_IDLE;
                next_s.sdo    = 1'b0;
                next_s.sdo_en = 1'b0;
            end
        endcase

        // consecutive miss counters, a good echo restarts them
        if (i_can_tx_followed | rx_fail) begin
            next_s.can_rx_miss = 3'h0;
        end else if (i_can_rx_missed) begin
            next_s.can_rx_miss = s.can_rx_miss + 3'h1;
        end
        if (i_can_tx_followed | bus_fail) begin
            next_s.can_bus_miss = 3'h0;
        end else if (i_can_bus_missed) begin
            next_s.can_bus_miss = s.can_bus_miss + 3'h1;
        end

        // transmitters stay off while a disabling flag stands
        next_s.lin_dis = flags_ls[`FSB_POS_LIN_TX_DOM] | flags_ls[`FSB_POS_LIN_STUCK_REC]
                         | set_ls[`FSB_POS_LIN_TX_DOM] | set_ls[`FSB_POS_LIN_STUCK_REC];
        next_s.can_dis = flags_ls[`FSB_POS_CAN_RX_REC] | flags_ls[`FSB_POS_CAN_BUS_REC]
                         | flags_ls[`FSB_POS_CAN_TX_DOM]
                         | set_ls[`FSB_POS_CAN_RX_REC] | set_ls[`FSB_POS_CAN_BUS_REC]
                         | set_ls[`FSB_POS_CAN_TX_DOM];

        // bridge held off until its flag pair is cleared
        next_s.bridge_off = {|(flags_oc[11:10] | set_oc[11:10]),
                             |(flags_oc[9:8] | set_oc[9:8]),
                             |(flags_oc[7:6] | set_oc[7:6])};
        next_s.bridge_rec = {|(i_bridge_overcurrent[5:4] & bridge_en[5:4]),
                             |(i_bridge_overcurrent[3:2] & bridge_en[3:2]),
                             |(i_bridge_overcurrent[1:0] & bridge_en[1:0])};
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            s <= TOP_RST;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs straight from state flops
    assign o_sdo             = s.sdo;
    assign o_sdo_en          = s.sdo_en;
    assign o_lin_tx_disable  = s.lin_dis;
    assign o_can_tx_disable  = s.can_dis;
    assign o_bridge_off      = s.bridge_off;
    assign o_bridge_recovery = s.bridge_rec;

endmodule : fsb_fault_latch

//--- src/fsb_pkg.sv
package fsb_pkg;

    // serial frame engine states, one-hot
    typedef enum logic [2:0] {
        FSB_IDLE  = 3'h1,
        FSB_SHIFT = 3'h2,
        FSB_ABORT = 3'h4
    } fsb_state_t;

    // complete state of the top module
    typedef struct packed {
        fsb_state_t  state;
        logic [1:0]  sck_sync;
        logic [1:0]  cs_sync;
        logic [1:0]  sdi_sync;
        logic        sck_prev;
        logic        cs_prev;
        logic [5:0]  bit_cnt;
        logic [31:0] frame;
        logic [23:0] snap;
        logic [7:0]  glob;
        logic [31:0] cs_timer;
        logic [2:0]  can_rx_miss;
        logic [2:0]  can_bus_miss;
        logic        clk_cnt_err;
        logic        inv_frame;
        logic [23:0] clr_oc;
        logic [23:0] clr_ls;
        logic        sdo;
        logic        sdo_en;
        logic        lin_dis;
        logic        can_dis;
        logic [2:0]  bridge_off;
        logic [2:0]  bridge_rec;
    } fsb_top_t;

endpackage : fsb_pkg

//--- src/fsb_regs.svh
`ifndef FSB_REGS_SVH
`define FSB_REGS_SVH

// register addresses on the serial port
`define FSB_ADDR_OVERCURRENT   6'h06
`define FSB_ADDR_LINK_SUPPLY   6'h07

// implemented bit masks, reserved positions read as zero
`define FSB_MASK_OVERCURRENT   24'h3f7fc0
`define FSB_MASK_LINK_SUPPLY   24'hffffef

// overcurrent_shutdown_flags field positions
`define FSB_POS_SWITCH_HI      16
`define FSB_POS_SWITCH_LO      12
`define FSB_POS_BRIDGE         6

// link_supply_fault_flags field positions
`define FSB_POS_LIN_TX_DOM     22
`define FSB_POS_LIN_STUCK_REC  21
`define FSB_POS_CAN_RX_REC     20
`define FSB_POS_CAN_BUS_REC    19
`define FSB_POS_CAN_TX_DOM     17

// serial frame layout and operation codes
`define FSB_FRAME_BITS         6'd32
`define FSB_HEAD_BITS          6'd8
`define FSB_OP_WRITE           2'h0
`define FSB_OP_READ            2'h1
`define FSB_OP_READ_CLEAR      2'h2
`define FSB_OP_UNDEFINED       2'h3

// timing
`define FSB_CLK_MHZ            100
`define FSB_CS_TIMEOUT_US      10000
`define FSB_CAN_FAIL_COUNT     4

`endif

//--- src/fsb_sticky_flags.sv
`timescale 1ns/1ps

module fsb_sticky_flags #(
    parameter int          WIDTH = 24,
    parameter logic [23:0] MASK  = 24'hffffff
) (
    input  wire logic             i_clk,
    input  wire logic             i_sys_rst,
    input  wire logic [WIDTH-1:0] i_set,
    input  wire logic [WIDTH-1:0] i_clear,
    output logic      [WIDTH-1:0] o_flags
);

    typedef struct packed {
        logic [WIDTH-1:0] flags;
    } fsb_sticky_t;

    fsb_sticky_t s;
    fsb_sticky_t next_s;

    ////////////////////////////////////////////////////////////////////////////
    // a set in the clearing cycle wins, so no event is lost
    always_comb begin
        next_s       = s;
        next_s.flags = ((s.flags & ~i_clear) | i_set) & MASK[WIDTH-1:0];
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign o_flags = s.flags;

endmodule : fsb_sticky_flags
